// >>> hdl/packed_ring_pkg.sv
// constants and types for the packed ring driver-side controller
package packed_ring_pkg;
  // ==========================================
  // software register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_QSIZE = 8'h04;
  localparam logic [7:0] REG_RING_BASE = 8'h08;
  localparam logic [7:0] REG_EVT_ADDR = 8'h0C;
  localparam logic [7:0] REG_BUF_LO = 8'h10;
  localparam logic [7:0] REG_BUF_HI = 8'h14;
  localparam logic [7:0] REG_BUF_LEN = 8'h18;
  localparam logic [7:0] REG_BUF_PUSH = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_USED = 8'h24;
  localparam logic [7:0] REG_CMD = 8'h28;
  localparam logic [7:0] REG_NEXT = 8'h2C;
  // ==========================================
  // field positions
  localparam int CTRL_NOTIF_DATA = 0;
  localparam int CTRL_PACKED = 1;
  localparam int CTRL_INDIRECT = 2;
  localparam int CTRL_QNUM_LSB = 16;
  localparam int CMD_ZERO = 0;
  localparam int CMD_RECLAIM = 1;
  localparam int CMD_RENOTIFY = 2;
  localparam int PUSH_WRITE = 0;
  localparam int PUSH_INDIRECT = 1;
  localparam int PUSH_LAST = 2;
  localparam int ERR_W = 5;
  localparam int ERR_LEN = 0;
  localparam int ERR_ORDER = 1;
  localparam int ERR_ROOM = 2;
  localparam int ERR_IND = 3;
  localparam int ERR_OVR = 4;
  localparam int ST_ERR_LSB = 1;
  localparam int ST_AVAIL_WRAP = 6;
  localparam int ST_USED_WRAP = 7;
  localparam int EVT_FLAGS_LSB = 16;
  localparam int FLAGS_LSB = 16;
  localparam int F_AVAIL_BIT = 7;
  localparam int F_USED_BIT = 15;
  // ==========================================
  // descriptor and event suppression encodings
  localparam logic [15:0] DESC_F_NEXT = 16'h0001;
  localparam logic [15:0] DESC_F_WRITE = 16'h0002;
  localparam logic [15:0] DESC_F_INDIRECT = 16'h0004;
  localparam logic [15:0] DESC_F_AVAIL = 16'h0080;
  localparam logic [15:0] DESC_F_USED = 16'h8000;
  localparam logic [1:0] EVT_ENABLE = 2'h0;
  localparam logic [1:0] EVT_DISABLE = 2'h1;
  localparam logic [1:0] EVT_DESC = 2'h2;
  localparam logic [3:0] DESC_SHIFT = 4'h0;
  localparam logic [2:0] W_ADDR_LO = 3'h0;
  localparam logic [2:0] W_ADDR_HI = 3'h1;
  localparam logic [2:0] W_LEN = 3'h2;
  localparam logic [2:0] W_ID = 3'h3;
  localparam logic [2:0] W_FLAGS = 3'h4;
  localparam logic [3:0] BE_LO = 4'h3;
  localparam logic [3:0] BE_HI = 4'hC;
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================
  // sizes and reset values
  localparam int MAX_CHAIN = 8;
  localparam logic [3:0] DEV_CHAIN_LIMIT = 4'h8;
  localparam int ID_SLOTS = 16;
  localparam logic [15:0] QSIZE_RST = 16'h0008;
  localparam logic [14:0] IDX_ZERO = 15'h0000;
  localparam logic [14:0] IDX_ONE = 15'h0001;
  localparam logic WRAP_RST = 1'b1;

  typedef enum logic [3:0] {
    S_IDLE, S_ZERO, S_CHECK, S_WRITE_DESC, S_WRITE_FIRST, S_READ_EVT, S_NOTIFY, S_RECL_READ, S_RECL_STEP
  } state_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [31:0] len;
    logic wr;
    logic ind;
  } elem_t;
endpackage : packed_ring_pkg

// >>> hdl/packed_ring_driver.sv
// driver-side packed ring controller: posts descriptor chains, notifies, reclaims used entries
// Operation
// - descriptors touched only after reclaim sees used; never after avail flag written.
// - notification carries offset and wrap of next not-yet-available descriptor.
// - repeat notifications allowed on command, carrying unchanged offset and wrap.
// - chain longer than queue size or device limit is refused.
// - device-writable elements must follow every device-readable element.
// - ring must have room for whole chain before first descriptor exposed.
// - first descriptor exposed only after all following descriptors are exposed.
// - indirect flag only with indirect feature; indirect tables carry only write flag.
// - indirect descriptor never inside a next-linked chain; chain limit kept.
// - each element takes next ring entry, buffer id; write flag when device-writable.
// - avail flag equals driver wrap counter, used flag its complement.
// - after last ring entry invert wrap counter and restart at zero.
// - available and used wrap counters both start at one.
// - flags word written after other fields; first flags deferred to chain end.
// - flags visible before event suppression read; notify only if not suppressed.
// - notify whenever device event flags differ from the disable value.
// - without notification data, notification carries only the queue number.
// - packed: next offset and wrap; otherwise low 15 bits and bit 15 of index.
// - ring entries are zeroed before first use.
// - event flags encode enable, disable, descriptor-specific; last code reserved.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module packed_ring_driver
  import packed_ring_pkg::*;
(
  input wire logic core_clk, // 10 MHz system clock
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes (full words assumed)
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic memReq, // shared memory request, held until memAck
  output logic memWe, // 1 write, 0 read
  output logic [31:0] memAddr, // word-aligned byte address
  output logic [31:0] memWdata, // write data
  output logic [3:0] memBe, // byte enables of a write
  input wire logic [31:0] memRdata, // read data, valid with memAck
  input wire logic memAck, // one-cycle completion of memReq
  output logic notifyValid, // one-cycle available buffer notification
  output logic [31:0] notifyData // queue number and optional next offset/wrap
);

  typedef struct packed {
    state_t st;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] ringBase;
    logic [31:0] evtAddr;
    logic [31:0] bufLo;
    logic [31:0] bufHi;
    logic [31:0] bufLen;
    logic [15:0] qsize;
    logic [15:0] freeCount;
    logic [15:0] availIdx;
    logic [15:0] usedCount;
    logic [15:0] lastUsedId;
    logic [14:0] nextAvail;
    logic [14:0] nextUsed;
    logic [14:0] curIdx;
    logic [14:0] firstIdx;
    logic availWrap;
    logic usedWrap;
    logic curWrap;
    logic [ERR_W-1:0] errs;
    elem_t [MAX_CHAIN-1:0] elems;
    logic [3:0] elemCnt;
    logic tooMany;
    logic [ID_SLOTS-1:0][3:0] sgs;
    logic [3:0] nextId;
    logic [3:0] elemIdx;
    logic [2:0] wsel;
    logic [15:0] firstFlags;
    logic [3:0] steps;
    logic postReq;
    logic zeroReq;
    logic reclReq;
    logic renotReq;
    logic memReq;
    logic memWe;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic [3:0] memBe;
    logic notifyValid;
    logic [31:0] notifyData;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ==========================================
  // helpers
  function automatic logic [15:0] stepIdx(input logic [14:0] idx, input logic wrap, input logic [15:0] qs);
    logic [15:0] res;
    res = {wrap, 15'(idx + IDX_ONE)};
    if (16'({1'b0, idx} + 16'h0001) >= qs) begin
      res = {~wrap, IDX_ZERO};
    end
    return res;
  endfunction : stepIdx

  function automatic logic [31:0] descAddr(input logic [31:0] base, input logic [14:0] idx, input logic [2:0] w);
    return 32'(base + 32'({idx, DESC_SHIFT}) + 32'({w[1:0], 2'b00}));
  endfunction : descAddr

  function automatic logic [31:0] readReg(input regs_t s, input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a == REG_CTRL) begin
      v = s.ctrl;
    end else if (a == REG_QSIZE) begin
      v = {16'h0000, s.qsize};
    end else if (a == REG_RING_BASE) begin
      v = s.ringBase;
    end else if (a == REG_EVT_ADDR) begin
      v = s.evtAddr;
    end else if (a == REG_BUF_LO) begin
      v = s.bufLo;
    end else if (a == REG_BUF_HI) begin
      v = s.bufHi;
    end else if (a == REG_BUF_LEN) begin
      v = s.bufLen;
    end else if (a == REG_STATUS) begin
      v = {s.freeCount, 8'h00, s.usedWrap, s.availWrap, s.errs, s.st != S_IDLE};
    end else if (a == REG_USED) begin
      v = {s.usedCount, s.lastUsedId};
    end else if (a == REG_NEXT) begin
      v = {s.availIdx, s.availWrap, s.nextAvail};
    end
    return v;
  endfunction : readReg

  function automatic logic isMapped(input logic [7:0] a);
    return a <= REG_NEXT && a[1:0] == 2'b00;
  endfunction : isMapped

  // ==========================================
  // next state
  always_comb begin
    logic [ERR_W-1:0] errSet;
    logic [ERR_W-1:0] errClr;
    logic [15:0] flg;
    logic [15:0] stp;
    logic seenWr;
    logic doAdvance;
    elem_t e;
    errSet = '0;
    errClr = '0;
    flg = '0;
    stp = '0;
    seenWr = 1'b0;
    doAdvance = 1'b0;
    e = r.elems[r.elemIdx[2:0]];
    next_r = r;
    next_r.notifyValid = 1'b0;

    // AXI4-Lite write: address and data accepted together, then one response
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.awready) begin
      next_r.awready = 1'b0;
      next_r.wready = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (s_axi_awaddr == REG_CTRL) begin
        next_r.ctrl = s_axi_wdata;
      end else if (s_axi_awaddr == REG_QSIZE) begin
        if (r.st == S_IDLE) begin
          next_r.qsize = s_axi_wdata[15:0];
          next_r.freeCount = s_axi_wdata[15:0];
          next_r.nextAvail = IDX_ZERO;
          next_r.nextUsed = IDX_ZERO;
          next_r.availWrap = WRAP_RST;
          next_r.usedWrap = WRAP_RST;
          next_r.availIdx = '0;
        end else begin
          errSet[ERR_OVR] = 1'b1;
        end
      end else if (s_axi_awaddr == REG_RING_BASE) begin
        next_r.ringBase = s_axi_wdata;
      end else if (s_axi_awaddr == REG_EVT_ADDR) begin
        next_r.evtAddr = s_axi_wdata;
      end else if (s_axi_awaddr == REG_BUF_LO) begin
        next_r.bufLo = s_axi_wdata;
      end else if (s_axi_awaddr == REG_BUF_HI) begin
        next_r.bufHi = s_axi_wdata;
      end else if (s_axi_awaddr == REG_BUF_LEN) begin
        next_r.bufLen = s_axi_wdata;
      end else if (s_axi_awaddr == REG_BUF_PUSH) begin
        // element table is in use while a chain is being posted
        if (r.st != S_IDLE || r.postReq) begin
          errSet[ERR_OVR] = 1'b1;
        end else begin
          if (r.elemCnt >= DEV_CHAIN_LIMIT) begin
            next_r.tooMany = 1'b1;
          end else begin
            next_r.elems[r.elemCnt[2:0]] = '{addr: {r.bufHi, r.bufLo}, len: r.bufLen,
              wr: s_axi_wdata[PUSH_WRITE], ind: s_axi_wdata[PUSH_INDIRECT]};
            next_r.elemCnt = 4'(r.elemCnt + 4'h1);
          end
          next_r.postReq = s_axi_wdata[PUSH_LAST];
        end
      end else if (s_axi_awaddr == REG_STATUS) begin
        errClr = s_axi_wdata[ST_ERR_LSB +: ERR_W];
      end else if (s_axi_awaddr == REG_CMD) begin
        next_r.zeroReq = r.zeroReq | s_axi_wdata[CMD_ZERO];
        next_r.reclReq = r.reclReq | s_axi_wdata[CMD_RECLAIM];
        next_r.renotReq = r.renotReq | s_axi_wdata[CMD_RENOTIFY];
      end else if (!isMapped(s_axi_awaddr)) begin
        next_r.bresp = RESP_DECERR;
      end
    end else if (s_axi_awvalid && s_axi_wvalid && !r.bvalid) begin
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // AXI4-Lite read
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = readReg(r, s_axi_araddr);
      next_r.rresp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_arvalid && !r.rvalid) begin
      next_r.arready = 1'b1;
    end

    // ring engine
    case (r.st)
      S_IDLE: begin
        next_r.wsel = W_ADDR_LO;
        if (r.postReq) begin
          next_r.postReq = 1'b0;
          next_r.st = S_CHECK;
        end else if (r.zeroReq) begin
          next_r.zeroReq = 1'b0;
          next_r.curIdx = IDX_ZERO;
          next_r.st = S_ZERO;
        end else if (r.reclReq) begin
          next_r.reclReq = 1'b0;
          next_r.st = S_RECL_READ;
        end else if (r.renotReq) begin
          next_r.renotReq = 1'b0;
          next_r.st = S_READ_EVT;
        end
      end
      S_ZERO: begin
        if (!r.memReq) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b1;
          next_r.memAddr = descAddr(r.ringBase, r.curIdx, r.wsel);
          next_r.memWdata = '0;
          next_r.memBe = BE_ALL;
        end else if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.wsel = 3'(r.wsel + 3'h1);
          if (r.wsel == W_ID) begin
            next_r.wsel = W_ADDR_LO;
            next_r.curIdx = 15'(r.curIdx + IDX_ONE);
            if (16'({1'b0, r.curIdx} + 16'h0001) >= r.qsize) begin
              next_r.st = S_IDLE;
            end
          end
        end
      end
      S_CHECK: begin
        for (int i = 0; i < MAX_CHAIN; i++) begin
          if (4'(i) < r.elemCnt) begin
            if (seenWr && !r.elems[i].wr) begin
              errSet[ERR_ORDER] = 1'b1;
            end
            seenWr = seenWr | r.elems[i].wr;
            if (r.elems[i].ind && (!r.ctrl[CTRL_INDIRECT] || r.elemCnt != 4'h1)) begin
              errSet[ERR_IND] = 1'b1;
            end
          end
        end
        if (r.tooMany || r.elemCnt == 4'h0 || 16'(r.elemCnt) > r.qsize) begin
          errSet[ERR_LEN] = 1'b1;
        end
        if (16'(r.elemCnt) > r.freeCount) begin
          errSet[ERR_ROOM] = 1'b1;
        end
        next_r.curIdx = r.nextAvail;
        next_r.curWrap = r.availWrap;
        next_r.firstIdx = r.nextAvail;
        next_r.elemIdx = '0;
        next_r.wsel = W_ADDR_LO;
        if (errSet != '0) begin
          next_r.elemCnt = '0;
          next_r.tooMany = 1'b0;
          next_r.st = S_IDLE;
        end else begin
          next_r.sgs[r.nextId] = r.elemCnt;
          next_r.freeCount = 16'(r.freeCount - 16'(r.elemCnt));
          next_r.st = S_WRITE_DESC;
        end
      end
      S_WRITE_DESC: begin
        flg = (r.curWrap ? DESC_F_AVAIL : DESC_F_USED);
        if (e.wr && !e.ind) begin
          flg = flg | DESC_F_WRITE;
        end
        if (e.ind) begin
          flg = flg | DESC_F_INDIRECT;
        end
        if (4'(r.elemIdx + 4'h1) != r.elemCnt) begin
          flg = flg | DESC_F_NEXT;
        end
        if (!r.memReq) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b1;
          next_r.memAddr = descAddr(r.ringBase, r.curIdx, r.wsel == W_FLAGS ? W_ID : r.wsel);
          next_r.memBe = BE_ALL;
          case (r.wsel)
            W_ADDR_LO: next_r.memWdata = e.addr[31:0];
            W_ADDR_HI: next_r.memWdata = e.addr[63:32];
            W_LEN: next_r.memWdata = e.len;
            W_ID: begin
              next_r.memWdata = {16'h0000, 12'h000, r.nextId};
              next_r.memBe = BE_LO;
            end
            default: begin
              next_r.memWdata = {flg, 16'h0000};
              next_r.memBe = BE_HI;
            end
          endcase
        end else if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.wsel = 3'(r.wsel + 3'h1);
          if (r.wsel == W_ID && r.elemIdx == 4'h0) begin
            next_r.firstFlags = flg;
            doAdvance = 1'b1;
          end else if (r.wsel == W_FLAGS) begin
            doAdvance = 1'b1;
          end
        end
        if (doAdvance) begin
          stp = stepIdx(r.curIdx, r.curWrap, r.qsize);
          next_r.curIdx = stp[14:0];
          next_r.curWrap = stp[15];
          next_r.wsel = W_ADDR_LO;
          next_r.elemIdx = 4'(r.elemIdx + 4'h1);
          if (4'(r.elemIdx + 4'h1) == r.elemCnt) begin
            next_r.st = S_WRITE_FIRST;
          end
        end
      end
      S_WRITE_FIRST: begin
        if (!r.memReq) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b1;
          next_r.memAddr = descAddr(r.ringBase, r.firstIdx, W_ID);
          next_r.memWdata = {r.firstFlags, 16'h0000};
          next_r.memBe = BE_HI;
        end else if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.nextAvail = r.curIdx;
          next_r.availWrap = r.curWrap;
          next_r.availIdx = 16'(r.availIdx + 16'(r.elemCnt));
          next_r.nextId = 4'(r.nextId + 4'h1);
          next_r.elemCnt = '0;
          next_r.st = S_READ_EVT;
        end
      end
      S_READ_EVT: begin
        // memory port completes in order, so the flags write is visible before this read
        if (!r.memReq) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b0;
          next_r.memAddr = r.evtAddr;
          next_r.memBe = BE_ALL;
        end else if (memAck) begin
          next_r.memReq = 1'b0;
          if (memRdata[EVT_FLAGS_LSB +: 2] != EVT_DISABLE) begin
            next_r.st = S_NOTIFY;
          end else begin
            next_r.st = S_IDLE;
          end
        end
      end
      S_NOTIFY: begin
        next_r.notifyValid = 1'b1;
        if (!r.ctrl[CTRL_NOTIF_DATA]) begin
          next_r.notifyData = {16'h0000, r.ctrl[CTRL_QNUM_LSB +: 16]};
        end else if (r.ctrl[CTRL_PACKED]) begin
          next_r.notifyData = {r.availWrap, r.nextAvail, r.ctrl[CTRL_QNUM_LSB +: 16]};
        end else begin
          next_r.notifyData = {r.availIdx, r.ctrl[CTRL_QNUM_LSB +: 16]};
        end
        next_r.st = S_IDLE;
      end
      S_RECL_READ: begin
        if (!r.memReq) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b0;
          next_r.memAddr = descAddr(r.ringBase, r.nextUsed, W_ID);
          next_r.memBe = BE_ALL;
        end else if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.st = S_IDLE;
          if (memRdata[FLAGS_LSB + F_AVAIL_BIT] == r.usedWrap
              && memRdata[FLAGS_LSB + F_USED_BIT] == r.usedWrap) begin
            next_r.lastUsedId = memRdata[15:0];
            next_r.steps = r.sgs[memRdata[3:0]];
            next_r.freeCount = 16'(r.freeCount + 16'(r.sgs[memRdata[3:0]]));
            next_r.usedCount = 16'(r.usedCount + 16'h0001);
            next_r.st = S_RECL_STEP;
          end
        end
      end
      S_RECL_STEP: begin
        // skip over the whole chain that the one used entry stands for
        if (r.steps == 4'h0) begin
          next_r.st = S_RECL_READ;
        end else begin
          stp = stepIdx(r.nextUsed, r.usedWrap, r.qsize);
          next_r.nextUsed = stp[14:0];
          next_r.usedWrap = stp[15];
          next_r.steps = 4'(r.steps - 4'h1);
        end
      end
      default: next_r.st = S_IDLE;
    endcase

    // a hardware set in the clearing cycle wins
    next_r.errs = (r.errs & ~errClr) | errSet;
  end

  // ==========================================
  // state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= S_IDLE;
      r.qsize <= QSIZE_RST;
      r.freeCount <= QSIZE_RST;
      r.availWrap <= WRAP_RST;
      r.usedWrap <= WRAP_RST;
      r.curWrap <= WRAP_RST;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign memReq = r.memReq;
  assign memWe = r.memWe;
  assign memAddr = r.memAddr;
  assign memWdata = r.memWdata;
  assign memBe = r.memBe;
  assign notifyValid = r.notifyValid;
  assign notifyData = r.notifyData;
endmodule : packed_ring_driver

// >>> testbench/packed_ring_sva.sv
// port checker for the packed ring controller
`timescale 1ns/1ns
module packed_ring_sva (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic memReq, // request
  input wire logic memWe, // write
  input wire logic [31:0] memAddr, // address
  input wire logic [31:0] memWdata, // data
  input wire logic [3:0] memBe, // lanes
  input wire logic [31:0] memRdata, // read data
  input wire logic memAck, // done
  input wire logic notifyValid // notify
);
  // =====
  // checks
  logic evtOk;
  // word3 reads are reclaim; any other read is the event word
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst) evtOk <= 1'b0;
    else if (memAck) evtOk <= !memWe && memAddr[3:2] != 2'b11 && memRdata[17:16] != 2'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_evt; memAck && !memWe && memAddr[3:2] != 2'b11; endsequence
  sequence s_flags; memReq && memWe && memBe == 4'hC; endsequence
  a_flag_polarity: assert property (s_flags |-> memWdata[23] != memWdata[31])
    else $error("avail and used flags equal");
  a_ind_flags: assert property (s_flags ##0 memWdata[18] |-> memWdata[17:16] == 2'b00)
    else $error("indirect descriptor with next or write");
  a_word3_lanes: assert property (memReq && memWe && memBe != 4'hF |-> memAddr[3:2] == 2'b11)
    else $error("partial write outside id and flags word");
  a_hold_req: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata))
    else $error("memory request changed before answer");
  a_notify_on: assert property (s_evt ##0 memRdata[17:16] != 2'h1 |-> ##[1:4] notifyValid)
    else $error("notification missing");
  a_notify_off: assert property (s_evt ##0 memRdata[17:16] == 2'h1 |=> !notifyValid [*4])
    else $error("notification while suppressed");
  a_notify_cause: assert property (notifyValid |-> evtOk)
    else $error("notification without event read");
  a_pulse_once: assert property (notifyValid |=> !notifyValid)
    else $error("notification longer than one cycle");
endmodule : packed_ring_sva
bind packed_ring_driver packed_ring_sva chk (.*);

// >>> testbench/ring_device.sv
// shared ring memory with a consuming device
`timescale 1ns/1ns
module ring_device (
  input wire logic core_clk, // clock
  input wire logic memReq, // request
  input wire logic memWe, // write
  input wire logic [31:0] memAddr, // address
  input wire logic [31:0] memWdata, // data
  input wire logic [3:0] memBe, // lanes
  input wire logic [1:0] lat, // answer delay
  input wire logic useOne, // consume next entry
  output logic [31:0] memRdata, // read data
  output logic memAck // done
);
  // =====
  // memory and device
  logic [31:0] mem [0:63];
  logic [1:0] waitCnt = 2'h0;
  logic [2:0] devIdx = 3'h0;
  logic devWrap = 1'b1;
  logic [4:0] u;
  assign u = {devIdx, 2'h3};
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'hFFFF_FFFF;
    memAck = 1'b0;
    memRdata = 32'h0000_0000;
  end
  always @(posedge core_clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata; // stale read data never matches
    if (memReq && !memAck && waitCnt != 2'h0) waitCnt <= waitCnt - 2'h1;
    else if (memReq && !memAck) begin
      memAck <= 1'b1;
      waitCnt <= lat;
      memRdata <= mem[memAddr[7:2]];
      for (int b = 0; b < 4; b++) if (memWe && memBe[b]) mem[memAddr[7:2]][8*b+:8] <= memWdata[8*b+:8];
    end
    if (useOne && mem[u][23] == devWrap && mem[u][31] != devWrap) begin
      mem[u][31] <= devWrap;
      devIdx <= devIdx + 3'h1;
      if (devIdx == 3'h7) devWrap <= ~devWrap;
    end
  end
endmodule : ring_device

// >>> testbench/tb_packed_ring_driver.sv
// self-checking bench for the ring controller
`timescale 1ns/1ns
module tb_packed_ring_driver;
  import packed_ring_pkg::*;
  logic core_clk = 0, sys_rst = 1, useOne = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, memAddr, memWdata, memRdata, notifyData, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, memReq, memWe, memAck, notifyValid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lat = 0;
  logic [3:0] s_axi_wstrb = 4'hF, memBe;
  logic [32:0] rdQ[$], q;
  logic [31:0] ntQ[$];
  logic [31:0] ctl[3] = '{32'h0005_0003, 32'h0005_0002, 32'h0005_0001};
  logic [31:0] exn[3] = '{32'h0003_0005, 32'h0000_0005, 32'h000B_0005};
  int badCount = 0, samplesChecked = 0, cyc = 0;
  integer seed = 32'h9474;
  packed_ring_driver dut (.*);
  ring_device ring (.*);
  always #50 core_clk = ~core_clk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic giveVerdict;
    $display("checked %0d mismatched %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : giveVerdict
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic c);
    @(posedge core_clk);
    rdQ.push_back({c, e});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic idle;
    for (int i = 0; i < 100; i++) begin
      rd(REG_STATUS, 32'h0000_0000, 1'b0);
      if (d[0] === 1'b0) break;
    end
  endtask : idle
  task automatic post(input logic [2:0] f);
    wr(REG_BUF_LO, $random(seed));
    wr(REG_BUF_LEN, $random(seed));
    wr(REG_BUF_PUSH, {29'h0, f});
    idle();
  endtask : post
  // =====
  // watcher: oldest note per answer
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      badCount++;
      giveVerdict();
    end
    if (s_axi_rvalid && s_axi_rready && rdQ.size() > 0) begin
      q = rdQ.pop_front();
      if (q[32]) check("read", s_axi_rdata, q[31:0]);
    end
    if (notifyValid) check("notify", notifyData, ntQ.size() > 0 ? ntQ.pop_front() : 32'hDEAD_BEEF);
    if (s_axi_bvalid | s_axi_rvalid) check("resp", {s_axi_bresp, s_axi_rresp}, 0);
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    ring.mem[32] <= 32'h0000_0000;
    rd(REG_STATUS, 32'h0008_00C0, 1'b1);
    wr(REG_CTRL, ctl[0]);
    wr(REG_RING_BASE, 32'h0000_0000);
    wr(REG_EVT_ADDR, 32'h0000_0080);
    wr(REG_QSIZE, 32'h0000_0008);
    wr(REG_CMD, 32'h0000_0001);
    idle();
    for (int k = 1; k <= 10; k++) begin
      lat <= 2'($random(seed));
      ntQ.push_back({k < 8, 15'(k % 8), 16'h0005});
      post({2'b10, 1'($random(seed))});
      useOne <= 1'b1;
      @(posedge core_clk);
      useOne <= 1'b0;
      wr(REG_CMD, 32'h0000_0002);
      idle();
    end
    rd(REG_STATUS, 32'h0008_0000, 1'b1);
    rd(REG_NEXT, 32'h000A_0002, 1'b1);
    wr(REG_BUF_PUSH, 32'h0000_0001);
    post(3'b100);
    rd(REG_STATUS, 32'h0008_0004, 1'b1);
    wr(REG_STATUS, 32'h0000_003E);
    post(3'b110);
    rd(REG_STATUS, 32'h0008_0010, 1'b1);
    wr(REG_STATUS, 32'h0000_003E);
    repeat (8) wr(REG_BUF_PUSH, 32'h0000_0000);
    post(3'b100);
    rd(REG_STATUS, 32'h0008_0002, 1'b1);
    ring.mem[32] <= 32'h0001_0000;
    post(3'b100);
    for (int m = 0; m < 3; m++) begin
      ring.mem[32] <= {14'h0, 2'(m * 3), 16'h0000};
      wr(REG_CTRL, ctl[m]);
      ntQ.push_back(exn[m]);
      wr(REG_CMD, 32'h0000_0004);
      idle();
    end
    check("left", ntQ.size(), 0);
    giveVerdict();
  end
endmodule : tb_packed_ring_driver
